// ### hw/dual_wiper_regs.svh
`ifndef DUAL_WIPER_REGS_SVH
`define DUAL_WIPER_REGS_SVH

// Command byte fields
`define CMD_OP_HI 7
`define CMD_OP_LO 4
`define CMD_SEL_HI 3
`define CMD_SEL_LO 2
`define CMD_POT 0

// Instruction encodings
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'hA
`define OP_RD_SET 4'hB
`define OP_WR_SET 4'hC
`define OP_SET_TO_WIPER 4'hD
`define OP_WIPER_TO_SET 4'hE
`define OP_ALL_SET_TO_WIPER 4'h1

// Bit counts and reset values
`define BYTE_BITS 4'h8
`define LAST_SEND_BIT 4'h7
`define WIPER_RESET 6'h00
`define TAP_RESET 64'h0000000000000001
`define STORE_WORDS 8

// Nonvolatile write time and clock rate
`define NV_WRITE_TIME_US 5000
`define CLK_MHZ 200

`endif

// ### hw/dual_wiper_pkg.sv
package dual_wiper_pkg;

  // Six-bit wiper position
  typedef logic [5:0] pos_t;

  // Setting store word address: pot, then setting select
  typedef logic [2:0] store_addr_t;

  // Serial byte engine states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RECV = 5'h02,
    S_ACK = 5'h04,
    S_SEND = 5'h08,
    S_MACK = 5'h10
  } state_t;

endpackage

// ### hw/mem_if.sv
`timescale 1ns/1ps
// Link between the control logic and the setting store
interface mem_if;
  import dual_wiper_pkg::*;
  logic wr_en; // Write strobe
  store_addr_t wr_addr; // Word written
  pos_t wr_data; // Value written
  store_addr_t [1:0] rd_addr; // Word read, per pot
  pos_t [1:0] rd_data; // Registered read data, per pot
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ### hw/setting_store.sv
`timescale 1ns/1ps
`include "dual_wiper_regs.svh"
module setting_store
  import dual_wiper_pkg::*;
(
  // Clock
  input wire logic clk,
  // Control side
  mem_if.store bus
);
  pos_t mem [`STORE_WORDS]; // Kept across reset, as nonvolatile words
  pos_t [1:0] next_rd; // Next read data per port

  // Power-on content
  initial begin
    for (int i = 0; i < `STORE_WORDS; i++) begin
      mem[i] = `WIPER_RESET;
    end
  end

  // Read ports, a write to the same word passes through
  genvar p;
  for (p = 0; p < 2; p++) begin : g_rd
    always_comb begin
      if (bus.wr_en && bus.wr_addr == bus.rd_addr[p]) begin
        next_rd[p] = bus.wr_data;
      end else begin
        next_rd[p] = mem[bus.rd_addr[p]];
      end
    end
  end

  // Store the write and register read data
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
    bus.rd_data <= next_rd;
  end

endmodule // setting_store

// ### hw/dual_wiper_serial_slave.sv
`timescale 1ns/1ps
`include "dual_wiper_regs.svh"
// What this block does
// - Data line changes only while clock low
// - Start is data falling, clock high
// - Release data after eight bits, ack on ninth
// - Ack address, command and data byte
// - Master makes clock; slave never drives it
// - Upper address nibble must equal type code
// - Lower nibble must match all four straps
// - Straps give low four address bits
// - Write protect low blocks nonvolatile writes
// - Six-bit wiper, one-hot of sixty-four taps
// - Wiper loads directly or from setting
// - Settings kept in nonvolatile store
// - Stop after nonvolatile write starts busy
// - Busy lasts a configurable write time
// - No address ack while busy
// - Command: opcode, setting select, pot select
module dual_wiper_serial_slave
  import dual_wiper_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE = 4'hA, // Arbitrary type code
  parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus, clock is input only
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and protection
  input wire logic [3:0] address_strap_pins,
  input wire logic wp_n,
  // Pot state
  output pos_t [1:0] wiper_position_register,
  output logic [1:0][63:0] tap_select,
  output logic busy
);
  localparam int BW = $clog2(NV_WRITE_CYCLES + 1); // Busy counter width

  // Refuse a write time too short to hold busy for two cycles
  if (NV_WRITE_CYCLES < 2) begin : g_bad_time
    $error("NV_WRITE_CYCLES must be at least two");
  end

  logic scl_m, scl_s, scl_q; // Clock synchroniser and edge stage
  logic sda_m, sda_s, sda_q; // Data synchroniser and edge stage
  logic scl_rise, scl_fall, start_det, stop_det; // Bus events
  state_t state, next_state; // Byte engine state
  logic [3:0] bit_cnt, next_bit_cnt; // Bits in current byte
  logic [7:0] shift, next_shift; // Byte shifter
  logic [1:0] byte_idx, next_byte_idx; // 0 address, 1 command, 2 data
  logic [7:0] cmd, next_cmd; // Command byte
  pos_t data, next_data; // Data byte payload
  logic pend, next_pend; // Instruction complete, waits for stop
  logic next_sda_oe; // Next data pull-down
  pos_t [1:0] wiper, next_wiper; // Wiper positions
  logic [1:0][63:0] next_tap; // Next tap decode
  logic restore, next_restore; // Load wipers from store after reset
  logic next_busy, start_busy; // Busy state and its trigger
  logic [BW-1:0] busy_cnt, next_busy_cnt; // Cycles left in write
  logic [3:0] op; // Command opcode
  logic pot; // Command pot select
  logic addr_match, byte_ok, is_read, is_write, nv_op; // Decodes
  pos_t send_val; // Value a read returns

  mem_if mif ();

  // Nonvolatile setting store
  setting_store u_store (
    .clk(clk),
    .bus(mif.store)
  );

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign wiper_position_register = wiper;

  // Two-stage synchronisers plus one stage for edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_q} <= 3'h7;
      {sda_m, sda_s, sda_q} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_q} <= {scl, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
    end
  end

  // Edge and condition detection on synchronised lines
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // Command and address decodes
  assign op = cmd[`CMD_OP_HI:`CMD_OP_LO];
  assign pot = cmd[`CMD_POT];
  assign addr_match = shift[7:4] == DEVICE_TYPE
    && shift[3:0] == address_strap_pins;
  assign is_read = op == `OP_RD_WIPER || op == `OP_RD_SET;
  assign is_write = op == `OP_WR_WIPER || op == `OP_WR_SET;
  assign nv_op = op == `OP_WR_SET || op == `OP_WIPER_TO_SET;
  assign send_val = op == `OP_RD_WIPER ? wiper[pot] : mif.rd_data[pot];

  // Which bytes earn an acknowledge
  always_comb begin
    byte_ok = 1'b1;
    if (byte_idx == 2'h0) begin
      byte_ok = addr_match && !busy;
    end else if (byte_idx == 2'h1) begin
      case (shift[`CMD_OP_HI:`CMD_OP_LO])
        `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_SET, `OP_WR_SET,
        `OP_SET_TO_WIPER, `OP_WIPER_TO_SET,
        `OP_ALL_SET_TO_WIPER: byte_ok = 1'b1;
        default: byte_ok = 1'b0;
      endcase
    end
  end

  // Store read addresses follow the command's setting select
  always_comb begin
    mif.rd_addr[0] = {1'b0, cmd[`CMD_SEL_HI:`CMD_SEL_LO]};
    mif.rd_addr[1] = {1'b1, cmd[`CMD_SEL_HI:`CMD_SEL_LO]};
    mif.wr_addr = {pot, cmd[`CMD_SEL_HI:`CMD_SEL_LO]};
    mif.wr_data = op == `OP_WR_SET ? data : wiper[pot];
  end

  // Byte engine, acknowledge and instruction execution
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_byte_idx = byte_idx;
    next_cmd = cmd;
    next_data = data;
    next_pend = pend;
    next_sda_oe = sda_oe;
    next_wiper = wiper;
    next_restore = 1'b0;
    start_busy = 1'b0;
    mif.wr_en = 1'b0;
    if (restore) begin
      next_wiper = mif.rd_data;
    end
    if (start_det) begin
      // Start or repeated start: expect an address
      next_state = S_RECV;
      next_bit_cnt = 4'h0;
      next_byte_idx = 2'h0;
      next_pend = 1'b0;
      next_sda_oe = 1'b0;
    end else if (stop_det) begin
      // Stop runs the completed instruction
      next_state = S_IDLE;
      next_pend = 1'b0;
      next_sda_oe = 1'b0;
      if (pend) begin
        case (op)
          `OP_WR_WIPER: next_wiper[pot] = data;
          `OP_SET_TO_WIPER: next_wiper[pot] = mif.rd_data[pot];
          `OP_ALL_SET_TO_WIPER: next_wiper = mif.rd_data;
          `OP_WR_SET, `OP_WIPER_TO_SET: begin
            mif.wr_en = wp_n;
            start_busy = wp_n;
          end
          default: ;
        endcase
      end
    end else begin
      case (state)
        S_RECV: begin
          if (scl_rise && bit_cnt != `BYTE_BITS) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
            // Ninth clock: pull low to acknowledge
            next_state = byte_ok ? S_ACK : S_IDLE;
            next_sda_oe = byte_ok;
            if (byte_idx == 2'h1) begin
              next_cmd = shift;
            end
            if (byte_idx == 2'h2) begin
              next_data = shift[5:0];
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            // End of ninth clock: release, pick next phase
            next_sda_oe = 1'b0;
            next_bit_cnt = 4'h0;
            next_byte_idx = byte_idx + 2'h1;
            if (byte_idx == 2'h0 || (byte_idx == 2'h1 && is_write)) begin
              next_state = S_RECV;
            end else if (byte_idx == 2'h1 && is_read) begin
              next_state = S_SEND;
              next_shift = {2'h0, send_val};
              next_sda_oe = 1'b1; // Top bit of a read is zero
            end else begin
              next_state = S_IDLE;
              next_pend = 1'b1;
            end
          end
        end
        S_SEND: begin
          if (scl_fall) begin
            if (bit_cnt == `LAST_SEND_BIT) begin
              next_state = S_MACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        S_MACK: begin
          // Single byte reads: master ack is not used
          if (scl_rise) begin
            next_state = S_IDLE;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  // Byte engine registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      byte_idx <= 2'h0;
      cmd <= 8'h00;
      data <= `WIPER_RESET;
      pend <= 1'b0;
      sda_oe <= 1'b0;
      wiper <= {2{`WIPER_RESET}};
      restore <= 1'b1;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      byte_idx <= next_byte_idx;
      cmd <= next_cmd;
      data <= next_data;
      pend <= next_pend;
      sda_oe <= next_sda_oe;
      wiper <= next_wiper;
      restore <= next_restore;
    end
  end

  // One-hot tap decode per pot
  genvar p;
  for (p = 0; p < 2; p++) begin : g_tap
    assign next_tap[p] = `TAP_RESET << next_wiper[p];
  end

  // Tap registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tap_select <= {2{`TAP_RESET}};
    end else begin
      tap_select <= next_tap;
    end
  end

  // Nonvolatile write timer
  always_comb begin
    next_busy = busy;
    next_busy_cnt = busy_cnt;
    if (start_busy) begin
      next_busy = 1'b1;
      next_busy_cnt = BW'(NV_WRITE_CYCLES - 1);
    end else if (busy) begin
      if (busy_cnt == '0) begin
        next_busy = 1'b0;
      end else begin
        next_busy_cnt = busy_cnt - 1'b1;
      end
    end
  end

  // Busy registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      busy_cnt <= '0;
    end else begin
      busy <= next_busy;
      busy_cnt <= next_busy_cnt;
    end
  end

  // Checks on the serial engine
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_end;
    state == S_RECV && byte_idx == 2'h0 && bit_cnt == `BYTE_BITS
      && scl_fall;
  endsequence

  sequence s_data_end;
    state == S_RECV && byte_idx == 2'h2 && bit_cnt == `BYTE_BITS
      && scl_fall;
  endsequence

  a_sda_low_scl: assert property (
    $changed(sda_oe) |-> !scl_s && $past(scl_fall))
    else $error("data pull changed outside clock low");
  a_idle_until_start: assert property (
    state == S_IDLE && !start_det |=> state == S_IDLE)
    else $error("left idle without a start");
  a_recv_released: assert property (
    state == S_RECV |-> !sda_oe)
    else $error("data pulled while receiving");
  a_data_ack: assert property (
    s_data_end |=> sda_oe && state == S_ACK)
    else $error("data byte not acknowledged");
  a_addr_match_ack: assert property (
    s_addr_end and !busy |=> sda_oe == $past(addr_match))
    else $error("address ack does not follow match");
  a_busy_no_ack: assert property (
    s_addr_end and busy |=> !sda_oe ##1 state == S_IDLE)
    else $error("address acknowledged while busy");
  a_wp_blocks: assert property (
    mif.wr_en |-> wp_n && !busy)
    else $error("nonvolatile write while protected");
  a_tap_one_hot: assert property (
    $onehot(tap_select[0]) && $onehot(tap_select[1]))
    else $error("tap select not one-hot");
  a_stop_busy: assert property (
    stop_det && pend && nv_op && wp_n |=> busy ##1 busy)
    else $error("busy not started by stop");

endmodule // dual_wiper_serial_slave

// ### verif/bus_master_model.sv
`timescale 1ns/1ps
// Two-wire bus master: makes the clock, pulls data low
module bus_master_model #(
  parameter int HALF = 8 // Cycles per clock phase
) (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // One clock phase, then step off the edge
  task automatic half();
    repeat (HALF) @(posedge clk);
    #1;
  endtask

  // Start: data falls while clock is high
  task automatic start_c();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask

  // Stop: data rises while clock is high
  task automatic stop_c();
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask

  // One bit; data moves only with clock low
  task automatic bit_c(input logic b, output logic s);
    sda_pull = !b;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
    half();
  endtask

  // Byte out MSB first, ninth clock reads the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], s);
    end
    bit_c(1'b1, s);
    ack = !s;
  endtask

  // Byte in with data released, then no ack
  task automatic recv_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      b[i] = s;
    end
    bit_c(1'b1, s);
  endtask
endmodule // bus_master_model

// ### verif/dual_wiper_serial_slave_tb.sv
`timescale 1ns/1ps
`define CHECK(nm, got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
  end \
end
module dual_wiper_serial_slave_tb
  import dual_wiper_pkg::*;
;
  localparam logic [3:0] TYPE_CODE = 4'h3; // Arbitrary type code
  localparam logic [3:0] STRAP = 4'h6; // Strap setting
  localparam logic [7:0] ADDR = {TYPE_CODE, STRAP};
  // Clock, reset, bus
  logic clk = 1'b0;
  logic rst_n;
  wire logic scl;
  wire logic sda;
  wire logic pull;
  logic sda_o;
  logic sda_oe;
  // Straps and pot state
  logic [3:0] strap;
  logic wp_n;
  pos_t [1:0] wiper;
  logic [1:0][63:0] tap;
  logic busy;
  logic [7:0] rd;
  int mismatches = 0;
  int tests_run = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Open drain wire with pull-up
  assign sda = (pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  // Design under test
  dual_wiper_serial_slave #(
    .DEVICE_TYPE(TYPE_CODE),
    .NV_WRITE_CYCLES(600)
  ) dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .address_strap_pins(strap),
    .wp_n(wp_n), .wiper_position_register(wiper),
    .tap_select(tap), .busy(busy)
  );

  // Far side bus master
  bus_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));

  // Verdict and end of run
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Address only, expected ack given
  task automatic probe(input logic [7:0] a, input logic exp);
    logic k;
    m.start_c();
    m.send_byte(a, k);
    m.stop_c();
    `CHECK("probe ack", k, exp)
  endtask

  // Kind 0: two bytes, 1: plus data, 2: plus read
  task automatic txn(input logic [7:0] cmd, input logic cack,
                     input int kind, input logic [7:0] d,
                     output logic [7:0] r);
    logic k;
    r = 8'h00;
    m.start_c();
    m.send_byte(ADDR, k);
    `CHECK("addr ack", k, 1'b1)
    m.send_byte(cmd, k);
    `CHECK("cmd ack", k, cack)
    if (kind == 1) begin
      m.send_byte(d, k);
      `CHECK("data ack", k, 1'b1)
    end
    if (kind == 2) m.recv_byte(r);
    m.stop_c();
  endtask

  // Poll the address until the write finishes
  task automatic poll();
    logic k;
    k = 1'b0;
    for (int n = 0; n < 20; n++) begin
      m.start_c();
      m.send_byte(ADDR, k);
      m.stop_c();
      if (n == 0) `CHECK("busy ack", k, 1'b0)
      if (k === 1'b1) break;
    end
    `CHECK("poll ack", k, 1'b1)
    if (k !== 1'b1) report_and_stop();
    `CHECK("busy end", busy, 1'b0)
  endtask

  // Reset pulse, then settle off the clock edge
  task automatic reset_pulse();
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Main sequence
  initial begin
    wp_n = 1'b1;
    strap = STRAP;
    reset_pulse();
    `CHECK("wiper0", wiper[0], 6'h00)
    `CHECK("tap0", tap[0], 64'h1)
    `CHECK("busy", busy, 1'b0)
    `CHECK("sda_o", sda_o, 1'b0)
    // Direct wiper write and read back
    txn(8'hA1, 1'b1, 1, 8'h15, rd);
    `CHECK("wiper1", wiper[1], 6'h15)
    `CHECK("tap1", tap[1], 64'h1 << 8'h15)
    txn(8'h91, 1'b1, 2, 8'h00, rd);
    `CHECK("rd wiper", rd, 8'h15)
    // Unknown opcode and foreign addresses refused, address of a new strap setting accepted
    txn(8'h70, 1'b0, 0, 8'h00, rd);
    probe({TYPE_CODE ^ 4'h1, STRAP}, 1'b0);
    probe({TYPE_CODE, STRAP ^ 4'h8}, 1'b0);
    strap = 4'h9;
    probe({TYPE_CODE, 4'h9}, 1'b1);
    strap = STRAP;
    // Setting write, busy, polling, read back
    txn(8'hC8, 1'b1, 1, 8'hEA, rd);
    `CHECK("busy nv", busy, 1'b1)
    poll();
    txn(8'hB8, 1'b1, 2, 8'h00, rd);
    `CHECK("rd set", rd, 8'h2A)
    // Protected write is dropped
    wp_n = 1'b0;
    txn(8'hC8, 1'b1, 1, 8'h11, rd);
    `CHECK("busy wp", busy, 1'b0)
    wp_n = 1'b1;
    txn(8'hB8, 1'b1, 2, 8'h00, rd);
    `CHECK("rd kept", rd, 8'h2A)
    // Setting to wiper
    txn(8'hD8, 1'b1, 0, 8'h00, rd);
    `CHECK("wiper0 ld", wiper[0], 6'h2A)
    `CHECK("tap0 ld", tap[0], 64'h1 << 8'h2A)
    // Wiper to setting, pot 1 slot 3
    txn(8'hED, 1'b1, 0, 8'h00, rd);
    `CHECK("busy xfer", busy, 1'b1)
    poll();
    txn(8'hBD, 1'b1, 2, 8'h00, rd);
    `CHECK("rd xfer", rd, 8'h15)
    // Global load of slot 3 into both wipers
    txn(8'hA1, 1'b1, 1, 8'h3F, rd);
    txn(8'h1C, 1'b1, 0, 8'h00, rd);
    `CHECK("glob0", wiper[0], 6'h00)
    `CHECK("glob1", wiper[1], 6'h15)
    // Slot 0 of pot 1 written, then restored by a second reset
    txn(8'hC1, 1'b1, 1, 8'h2C, rd);
    poll();
    reset_pulse();
    `CHECK("rst wiper0", wiper[0], 6'h00)
    `CHECK("rst wiper1", wiper[1], 6'h2C)
    `CHECK("rst tap1", tap[1], 64'h1 << 8'h2C)
    `CHECK("rst busy", busy, 1'b0)
    txn(8'h91, 1'b1, 2, 8'h00, rd);
    `CHECK("rd restored", rd, 8'h2C)
    report_and_stop();
  end
endmodule // dual_wiper_serial_slave_tb
